/* include/cspl_pkg.sv */
// Shared constants and types for the control store panel loader.
// Assumes a 100 MHz reference clock and an 8-bit wide control store port.
package cspl_pkg;

  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 8;
  localparam int FIELD_W = 2;

  localparam logic [ADDR_W-1:0]  ADDR_RESET  = 8'h00;
  localparam logic [ADDR_W-1:0]  ADDR_STEP   = 8'h01;
  localparam logic [FIELD_W-1:0] FIELD_RESET = 2'h0;
  localparam logic [FIELD_W-1:0] FIELD_STEP  = 2'h1;
  localparam logic [FIELD_W-1:0] FIELD_LAST  = 2'h3;
  localparam logic [DATA_W-1:0]  DATA_RESET  = 8'h00;
  localparam logic [1:0]         HOST_SEL    = 2'h3;

  // Panel button positions in the button vector
  localparam int SW_RUN_HALT  = 0;
  localparam int SW_LOAD_ADDR = 1;
  localparam int SW_DEPOSIT   = 2;
  localparam int SW_DEP_NEXT  = 3;
  localparam int SW_EXAM_NEXT = 4;
  localparam int SW_STEP      = 5;
  localparam int SW_MRESET    = 6;
  localparam int SW_COUNT     = 7;

  // Timing
  localparam int CLK_MHZ         = 100;
  localparam int DEBOUNCE_US     = 5000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;
  localparam int MICROCYCLE_CYC  = 2;
  localparam int BUF_DEPTH       = 2;

  typedef enum logic [2:0] {
    ST_HALT = 3'b000,
    ST_RUN  = 3'b001,
    ST_STEP = 3'b010,
    ST_EXAM = 3'b011
  } cspl_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0]  addr;
    logic [FIELD_W-1:0] field;
    logic [DATA_W-1:0]  wdata;
    logic               we;
  } cspl_cs_req_type;

endpackage

/* rtl/cspl_debounce.sv */
// Synchroniser, debouncer and press detector for one panel button.
// Assumes a raw, bouncing, active high button level from a pin.
`timescale 1ns/1ps
`default_nettype none
module cspl_debounce #(
  parameter int CNT_MAX = 500000
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  input  wire logic i_btn,
  output logic      o_press
);
  import cspl_pkg::*;

  localparam int CNT_W = $clog2(CNT_MAX + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CNT_MAX - 1);

  logic             meta_reg;
  logic             sync_reg;
  logic             level_reg;
  logic             level_prev_reg;
  logic [CNT_W-1:0] cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= i_btn;
      sync_reg <= meta_reg;
    end
  end

  // Level is accepted only after it has held for the full window
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg   <= '0;
      level_reg <= 1'b0;
    end else if (sync_reg == level_reg) begin
      cnt_reg <= '0;
    end else if (cnt_reg == CNT_LAST) begin
      cnt_reg   <= '0;
      level_reg <= sync_reg;
    end else begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level_prev_reg <= 1'b0;
    end else begin
      level_prev_reg <= level_reg;
    end
  end

  assign o_press = level_reg & ~level_prev_reg; // see [R15]

  ////////////////////////////////////////////////////////////////////////////
  AST_PRESS_SINGLE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R15]
    o_press |=> !o_press)
    else $error("press pulse longer than one cycle");

endmodule
`default_nettype wire

/* rtl/cspl_panel_loader.sv */
// Panel and host load control for a writable microprogram control store.
// Assumes an asynchronous-read control RAM and a sequencer giving next address.
//
// Behaviour
// [R1] Run/halt pressed while running, or master reset, puts the device in halt.
// [R2] Load, deposit, deposit-next, examine-next and step act only while halted.
// [R3] Master reset clears the address and field selector and leaves run lamp off.
// [R4] Load-address copies the switch byte into the address, shown on the lamps.
// [R5] Deposit writes the switch byte to the selected field, address and field kept.
// [R6] Deposit-next advances the field by one, then writes the switch byte there.
// [R7] Deposit-next with field 11 wraps the field to 00 and bumps the address first.
// [R8] Examine-next advances one field and shows its stored byte without writing.
// [R9] Single step runs exactly the microinstruction at the address, then halts.
// [R10] Run/halt while halted starts running from the address and lights run lamp.
// [R11] A qualified host write acts as deposit-next with the host byte.
// [R12] Host writes count only when both high host address bits are one.
// [R13] The operator loads the start address and first field before host loading.
// [R14] A halt while running takes effect only after the current microinstruction.
// [R15] Each panel press gives exactly one request pulse of one cycle.
// [R16] Examine-next advances field and address exactly as deposit-next does.
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cspl_panel_loader #(
  parameter int DEBOUNCE_CYCLES = cspl_pkg::DEBOUNCE_CYCLES,
  parameter int MICROCYCLE_CYC  = cspl_pkg::MICROCYCLE_CYC
) (
  input  wire logic                                   i_ref_clk,
  input  wire logic                                   i_rst_n,
  input  wire logic [cspl_pkg::SW_COUNT-1:0]          i_panel_buttons,
  input  wire logic [cspl_pkg::DATA_W-1:0]            i_sw_data,
  input  wire logic                                   i_host_mem_write_strobe_n,
  input  wire logic [1:0]                             i_host_addr_hi,
  input  wire logic [cspl_pkg::DATA_W-1:0]            i_host_data,
  output logic                                        o_host_ready,
  input  wire logic [cspl_pkg::DATA_W-1:0]            i_cs_rdata,
  output cspl_pkg::cspl_cs_req_type                   o_cs_req,
  input  wire logic [cspl_pkg::ADDR_W-1:0]            i_seq_next_addr,
  output logic                                        o_uinst_exec,
  output logic [cspl_pkg::ADDR_W-1:0]                 o_addr_lamps,
  output logic [cspl_pkg::DATA_W-1:0]                 o_data_lamps,
  output logic                                        o_field_sel_hi,
  output logic                                        o_field_sel_lo,
  output logic                                        o_run_lamp
);
  import cspl_pkg::*;

  localparam int UC_W = $clog2(MICROCYCLE_CYC + 1);
  localparam logic [UC_W-1:0] UC_LAST = UC_W'(MICROCYCLE_CYC - 1);

  function automatic logic [ADDR_W+FIELD_W-1:0] fn_advance(
    input logic [ADDR_W-1:0]  a,
    input logic [FIELD_W-1:0] f
  );
    fn_advance = (f == FIELD_LAST) ? {a + ADDR_STEP, FIELD_RESET}
                                   : {a, f + FIELD_STEP};
  endfunction

  cspl_state_type      state_reg;
  logic [SW_COUNT-1:0] press;
  logic [DATA_W-1:0]   sw_meta_reg;
  logic [DATA_W-1:0]   sw_reg;
  logic                strobe_meta_reg;
  logic                strobe_sync_reg;
  logic                strobe_prev_reg;
  logic [1:0]          hi_meta_reg;
  logic [1:0]          hi_reg;
  logic [DATA_W-1:0]   hdata_meta_reg;
  logic [DATA_W-1:0]   hdata_reg;
  logic                host_fall;
  logic                host_push;
  logic [DATA_W-1:0]   buf_mem [BUF_DEPTH];
  logic                buf_wr_idx_reg;
  logic                buf_rd_idx_reg;
  logic [1:0]          buf_cnt_reg;
  logic                buf_valid;
  logic [DATA_W-1:0]   buf_head;
  logic [ADDR_W-1:0]   addr_reg;
  logic [FIELD_W-1:0]  field_reg;
  logic [DATA_W-1:0]   wdata_reg;
  logic                we_reg;
  logic [DATA_W-1:0]   data_lamps_reg;
  logic [UC_W-1:0]     uc_cnt_reg;
  logic                halt_pend_reg;
  logic                halted;
  logic                mreset;
  logic                uc_end;
  logic                do_load;
  logic                do_dep;
  logic                do_depn;
  logic                do_exam;
  logic                do_step;
  logic                do_run;
  logic                do_host;

  ////////////////////////////////////////////////////////////////////////////
  // Panel buttons
  for (genvar i = 0; i < SW_COUNT; i++) begin : g_btn
    cspl_debounce #(
      .CNT_MAX (DEBOUNCE_CYCLES)
    ) u_deb (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_btn     (i_panel_buttons[i]),
      .o_press   (press[i])
    );
  end

  // Switches and host pins come from outside this clock domain
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sw_meta_reg     <= DATA_RESET;
      sw_reg          <= DATA_RESET;
      strobe_meta_reg <= 1'b1;
      strobe_sync_reg <= 1'b1;
      strobe_prev_reg <= 1'b1;
      hi_meta_reg     <= 2'h0;
      hi_reg          <= 2'h0;
      hdata_meta_reg  <= DATA_RESET;
      hdata_reg       <= DATA_RESET;
    end else begin
      sw_meta_reg     <= i_sw_data;
      sw_reg          <= sw_meta_reg;
      strobe_meta_reg <= i_host_mem_write_strobe_n;
      strobe_sync_reg <= strobe_meta_reg;
      strobe_prev_reg <= strobe_sync_reg;
      hi_meta_reg     <= i_host_addr_hi;
      hi_reg          <= hi_meta_reg;
      hdata_meta_reg  <= i_host_data;
      hdata_reg       <= hdata_meta_reg;
    end
  end

  // Address and data lag the strobe by the same two stages, so they line up
  assign host_fall = strobe_prev_reg & ~strobe_sync_reg;
  assign host_push = host_fall && (hi_reg == HOST_SEL) && o_host_ready; // see [R12]

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry host buffer; only drained while halted, so a running
  // machine pushes back on the host through o_host_ready
  assign o_host_ready = (buf_cnt_reg != 2'(BUF_DEPTH));
  assign buf_valid    = (buf_cnt_reg != 2'h0);
  assign buf_head     = buf_mem[buf_rd_idx_reg];

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      buf_mem[0] <= DATA_RESET;
      buf_mem[1] <= DATA_RESET;
    end else if (host_push) begin
      buf_mem[buf_wr_idx_reg] <= hdata_reg;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      buf_wr_idx_reg <= 1'b0;
      buf_rd_idx_reg <= 1'b0;
      buf_cnt_reg    <= 2'h0;
    end else begin
      if (host_push) begin
        buf_wr_idx_reg <= ~buf_wr_idx_reg;
      end
      if (do_host) begin
        buf_rd_idx_reg <= ~buf_rd_idx_reg;
      end
      if (host_push && !do_host) begin
        buf_cnt_reg <= buf_cnt_reg + 2'h1;
      end else if (!host_push && do_host) begin
        buf_cnt_reg <= buf_cnt_reg - 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request decode, one operation per cycle; panel wins over the host
  assign mreset  = press[SW_MRESET];
  assign halted  = (state_reg == ST_HALT) && !mreset;              // see [R2]
  assign do_load = halted && press[SW_LOAD_ADDR];
  assign do_dep  = halted && !do_load && press[SW_DEPOSIT];
  assign do_depn = halted && !do_load && !do_dep && press[SW_DEP_NEXT];
  assign do_exam = halted && !do_load && !do_dep && !do_depn && press[SW_EXAM_NEXT];
  assign do_step = halted && !(do_load | do_dep | do_depn | do_exam) && press[SW_STEP];
  assign do_run  = halted && !(do_load | do_dep | do_depn | do_exam | do_step)
                   && press[SW_RUN_HALT];
  assign do_host = halted && buf_valid && !(press[SW_LOAD_ADDR] | press[SW_DEPOSIT] |
                   press[SW_DEP_NEXT] | press[SW_EXAM_NEXT] | press[SW_STEP] |
                   press[SW_RUN_HALT]);                            // see [R11]

  assign uc_end = ((state_reg == ST_RUN) || (state_reg == ST_STEP)) && (uc_cnt_reg == UC_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_HALT;
    end else if (mreset) begin
      state_reg <= ST_HALT;                                        // see [R1]
    end else begin
      case (state_reg)
        ST_HALT: begin
          if (do_run) begin
            state_reg <= ST_RUN;                                   // see [R10]
          end else if (do_step) begin
            state_reg <= ST_STEP;                                  // see [R9]
          end else if (do_exam) begin
            state_reg <= ST_EXAM;
          end
        end
        ST_RUN: begin
          if (uc_end && (halt_pend_reg || press[SW_RUN_HALT])) begin
            state_reg <= ST_HALT;                                  // see [R1] [R14]
          end
        end
        ST_STEP: begin
          if (uc_end) begin
            state_reg <= ST_HALT;                                  // see [R9]
          end
        end
        ST_EXAM: state_reg <= ST_HALT;
        default: state_reg <= ST_HALT;
      endcase
    end
  end

  // A halt press mid-microcycle is held until the microcycle ends
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      halt_pend_reg <= 1'b0;
    end else if (state_reg != ST_RUN || mreset || uc_end) begin
      halt_pend_reg <= 1'b0;
    end else if (press[SW_RUN_HALT]) begin
      halt_pend_reg <= 1'b1;                                       // see [R14]
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      uc_cnt_reg <= '0;
    end else if (uc_end || !((state_reg == ST_RUN) || (state_reg == ST_STEP))) begin
      uc_cnt_reg <= '0;
    end else begin
      uc_cnt_reg <= uc_cnt_reg + UC_W'(1);
    end
  end

  assign o_uinst_exec = uc_end;

  ////////////////////////////////////////////////////////////////////////////
  // Address and field selector
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_reg  <= ADDR_RESET;
      field_reg <= FIELD_RESET;
    end else if (mreset) begin
      addr_reg  <= ADDR_RESET;                                     // see [R3]
      field_reg <= FIELD_RESET;
    end else if (do_load) begin
      addr_reg <= sw_reg;                                          // see [R4]
    end else if (do_depn || do_exam || do_host) begin
      {addr_reg, field_reg} <= fn_advance(addr_reg, field_reg);    // see [R6] [R7] [R16]
    end else if (uc_end) begin
      addr_reg <= i_seq_next_addr;
    end
  end

  // Store write goes out the cycle after the request, at the place then selected (advanced for deposit-next and host)
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      we_reg    <= 1'b0;
      wdata_reg <= DATA_RESET;
    end else begin
      we_reg <= do_dep || do_depn || do_host;                      // see [R5] [R8]
      if (do_dep || do_depn) begin
        wdata_reg <= sw_reg;
      end else if (do_host) begin
        wdata_reg <= buf_head;                                     // see [R11]
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_lamps_reg <= DATA_RESET;
    end else if (do_dep || do_depn) begin
      data_lamps_reg <= sw_reg;                                    // see [R5]
    end else if (do_host) begin
      data_lamps_reg <= buf_head;
    end else if (state_reg == ST_EXAM) begin
      data_lamps_reg <= i_cs_rdata;                                // see [R8]
    end
  end

  assign o_cs_req       = '{addr: addr_reg, field: field_reg, wdata: wdata_reg, we: we_reg};
  assign o_addr_lamps   = addr_reg;
  assign o_data_lamps   = data_lamps_reg;
  assign o_field_sel_hi = field_reg[1];
  assign o_field_sel_lo = field_reg[0];
  assign o_run_lamp     = (state_reg == ST_RUN);                   // see [R3] [R10]

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence seq_exam_done;
    (state_reg == ST_EXAM) && !we_reg ##1 (data_lamps_reg == $past(i_cs_rdata));
  endsequence

  sequence seq_step_done;
    ##[1:8] uc_end ##1 (state_reg == ST_HALT);
  endsequence

  AST_MRESET_CLEARS: assert property ( // [R3]
    mreset |=> (addr_reg == ADDR_RESET) && (field_reg == FIELD_RESET) && !o_run_lamp)
    else $error("master reset did not clear address and field");

  AST_LOAD_ADDR: assert property ( // [R4]
    do_load |=> (o_addr_lamps == $past(sw_reg)))
    else $error("load address did not take the switch byte");

  AST_DEPOSIT_KEEPS: assert property ( // [R5]
    do_dep |=> $stable(addr_reg) && $stable(field_reg) && we_reg
               && (o_data_lamps == $past(sw_reg)))
    else $error("deposit moved the address or wrote the wrong byte");

  AST_DEPN_ADVANCE: assert property ( // [R6]
    do_depn && (field_reg != FIELD_LAST) |=>
      (field_reg == $past(field_reg) + FIELD_STEP) && $stable(addr_reg) && we_reg)
    else $error("deposit next did not advance the field");

  AST_DEPN_WRAP: assert property ( // [R7]
    do_depn && (field_reg == FIELD_LAST) |=>
      (field_reg == FIELD_RESET) && (addr_reg == $past(addr_reg) + ADDR_STEP))
    else $error("deposit next did not wrap into the next address");

  AST_EXAM_READS: assert property ( // [R8]
    do_exam |=> seq_exam_done)
    else $error("examine next wrote or showed the wrong byte");

  AST_STEP_ONE: assert property ( // [R9]
    do_step |-> seq_step_done)
    else $error("single step did not halt after one microinstruction");

  AST_RUN_LAMP: assert property ( // [R10]
    do_run |=> o_run_lamp)
    else $error("run did not light the run lamp");

  AST_NO_WRITE_RUNNING: assert property ( // [R2]
    (state_reg != ST_HALT) |=> !we_reg)
    else $error("store written while not halted");

  AST_HALT_FINISHES: assert property ( // [R14]
    (state_reg == ST_RUN) && !uc_end && !mreset |=> (state_reg == ST_RUN))
    else $error("halt cut a microinstruction short");

  AST_HOST_ADVANCE: assert property ( // [R11]
    do_host && (field_reg != FIELD_LAST) |=>
      we_reg && (wdata_reg == $past(buf_head)) && (field_reg == $past(field_reg) + FIELD_STEP))
    else $error("host write did not act as deposit next");

  AST_HOST_QUALIFY: assert property ( // [R12]
    host_fall && (hi_reg != HOST_SEL) && !do_host |=> $stable(buf_cnt_reg))
    else $error("unqualified host write was taken");

endmodule
`default_nettype wire

/* tb/cspl_cs_ram_model.sv */
// Control RAM and fetch sequencer behind the panel loader.
// Assumes one clock; writes come as one-cycle strobes from the loader.
`timescale 1ns/1ps
`default_nettype none
module cspl_cs_ram_model (
  input  wire logic                         i_ref_clk,
  input  wire cspl_pkg::cspl_cs_req_type    i_cs_req,
  input  wire logic [cspl_pkg::ADDR_W-1:0]  i_cur_addr,
  output logic [cspl_pkg::DATA_W-1:0]       o_cs_rdata,
  output logic [cspl_pkg::ADDR_W-1:0]       o_seq_next_addr
);
  import cspl_pkg::*;
  ////////////////////////////////////////////////////////////
  logic [DATA_W-1:0] mem [0:1023];
  // Asynchronous read: the loader takes rdata in the same cycle
  assign o_cs_rdata = mem[{i_cs_req.addr, i_cs_req.field}];
  // Fetch only, so the address after N microinstructions is start plus N
  assign o_seq_next_addr = i_cur_addr + ADDR_STEP;
  always @(posedge i_ref_clk) begin
    if (i_cs_req.we === 1'b1) begin
      mem[{i_cs_req.addr, i_cs_req.field}] <= i_cs_req.wdata;
    end
  end
endmodule
`default_nettype wire

/* tb/test_control_store_panel_loader.sv */
// Self-checking bench for the panel loader.
// Assumes short debounce and microcycle counts set at the instance.
`timescale 1ns/1ps
`default_nettype none
module test_control_store_panel_loader;
  import cspl_pkg::*;
  localparam int DEB = 4;
  typedef struct {
    int         b;
    logic [7:0] s;
    logic [7:0] a;
    logic [1:0] f;
    logic [7:0] d;
    bit         cd;
  } cspl_row_type;
  logic                ref_clk  = 1'b0;
  logic                rst_n    = 1'b0;
  logic [SW_COUNT-1:0] btn      = 7'h00;
  logic [DATA_W-1:0]   sw       = 8'h00;
  logic [DATA_W-1:0]   hdata    = 8'h00;
  logic                strobe_n = 1'b1;
  logic [1:0]          hhi      = 2'h0;
  logic [DATA_W-1:0]   rdata;
  logic [DATA_W-1:0]   dlamp;
  logic [ADDR_W-1:0]   next_a;
  logic [ADDR_W-1:0]   alamp;
  logic [ADDR_W-1:0]   a;
  logic                ready;
  logic                exec;
  logic                f_hi;
  logic                f_lo;
  logic                run;
  cspl_cs_req_type     req;
  int                  err_count = 0;
  int                  checks    = 0;
  int                  execs     = 0;
  int                  n;
  cspl_row_type rows [15] = '{
    '{SW_LOAD_ADDR, 8'hFE, 8'hFE, 2'h0, 8'h00, 0},
    '{SW_DEPOSIT,   8'h11, 8'hFE, 2'h0, 8'h11, 1},
    '{SW_DEP_NEXT,  8'h22, 8'hFE, 2'h1, 8'h22, 1},
    '{SW_DEP_NEXT,  8'h33, 8'hFE, 2'h2, 8'h33, 1},
    '{SW_DEP_NEXT,  8'h44, 8'hFE, 2'h3, 8'h44, 1},
    '{SW_DEP_NEXT,  8'h55, 8'hFF, 2'h0, 8'h55, 1},
    '{SW_LOAD_ADDR, 8'hFE, 8'hFE, 2'h0, 8'h00, 0},
    '{SW_EXAM_NEXT, 8'h00, 8'hFE, 2'h1, 8'h22, 1},
    '{SW_EXAM_NEXT, 8'h00, 8'hFE, 2'h2, 8'h33, 1},
    '{SW_EXAM_NEXT, 8'h00, 8'hFE, 2'h3, 8'h44, 1},
    '{SW_EXAM_NEXT, 8'h00, 8'hFF, 2'h0, 8'h55, 1},
    '{SW_DEPOSIT,   8'h5A, 8'hFF, 2'h0, 8'h5A, 1},
    '{SW_MRESET,    8'h00, 8'h00, 2'h0, 8'h00, 0},
    '{SW_LOAD_ADDR, 8'h3F, 8'h3F, 2'h0, 8'h00, 0},
    '{SW_DEPOSIT,   8'h77, 8'h3F, 2'h0, 8'h77, 1}
  };
  ////////////////////////////////////////////////////////////
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (exec === 1'b1) begin
      execs <= execs + 1;
    end
  end
  cspl_panel_loader #(.DEBOUNCE_CYCLES(DEB), .MICROCYCLE_CYC(2)) DUT (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_panel_buttons(btn), .i_sw_data(sw),
    .i_host_mem_write_strobe_n(strobe_n), .i_host_addr_hi(hhi), .i_host_data(hdata),
    .o_host_ready(ready), .i_cs_rdata(rdata), .o_cs_req(req), .i_seq_next_addr(next_a),
    .o_uinst_exec(exec), .o_addr_lamps(alamp), .o_data_lamps(dlamp),
    .o_field_sel_hi(f_hi), .o_field_sel_lo(f_lo), .o_run_lamp(run)
  );
  cspl_cs_ram_model ram (
    .i_ref_clk(ref_clk), .i_cs_req(req), .i_cur_addr(alamp),
    .o_cs_rdata(rdata), .o_seq_next_addr(next_a)
  );
  ////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Held well past the debounce span so exactly one press is seen
  task automatic press(input int b, input logic [7:0] s);
    @(posedge ref_clk);
    sw <= s;
    btn[b] <= 1'b1;
    repeat (DEB + 8) @(posedge ref_clk);
    btn[b] <= 1'b0;
    repeat (DEB + 8) @(posedge ref_clk);
    #1;
  endtask
  // Low and high phases both longer than the three-flop sync
  task automatic host_wr(input logic [1:0] hi, input logic [7:0] d);
    @(posedge ref_clk);
    hhi <= hi;
    hdata <= d;
    strobe_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    strobe_n <= 1'b1;
    // Host moves on once the strobe is released
    hhi <= ~hi;
    hdata <= ~d;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    check("addr", alamp, 8'h00);
    check("field", {f_hi, f_lo}, 2'h0);
    check("run", run, 1'b0);
    check("ready", ready, 1'b1);
    for (int i = 0; i < 15; i++) begin
      press(rows[i].b, rows[i].s);
      check("addr", alamp, rows[i].a);
      check("field", {f_hi, f_lo}, rows[i].f);
      if (rows[i].cd) check("data", dlamp, rows[i].d);
    end
    // First field was deposited by hand above, host starts at the second
    for (int h = 0; h < 3; h++) begin
      host_wr(h[1:0], 8'h99);
      check("field", {f_hi, f_lo}, 2'h0);
      check("data", dlamp, 8'h77);
    end
    host_wr(2'h3, 8'h88);
    check("addr", alamp, 8'h3F);
    check("field", {f_hi, f_lo}, 2'h1);
    check("data", dlamp, 8'h88);
    check("ram", ram.mem[{8'h3F, 2'h1}], 8'h88);
    check("ram", ram.mem[{8'h3F, 2'h0}], 8'h77);
    // A bounce shorter than the debounce span, then a real press: one step only
    @(posedge ref_clk);
    btn[SW_DEP_NEXT] <= 1'b1;
    repeat (2) @(posedge ref_clk);
    btn[SW_DEP_NEXT] <= 1'b0;
    repeat (2) @(posedge ref_clk);
    press(SW_DEP_NEXT, 8'hC3);
    check("addr", alamp, 8'h3F);
    check("field", {f_hi, f_lo}, 2'h2);
    check("data", dlamp, 8'hC3);
    press(SW_MRESET, 8'h10);
    check("addr", alamp, 8'h00);
    check("field", {f_hi, f_lo}, 2'h0);
    press(SW_LOAD_ADDR, 8'h10);
    n = execs;
    press(SW_STEP, 8'h10);
    check("execs", 16'(execs - n), 16'h0001);
    check("addr", alamp, 8'h11);
    check("run", run, 1'b0);
    n = execs;
    press(SW_RUN_HALT, 8'h10);
    check("run", run, 1'b1);
    press(SW_LOAD_ADDR, 8'h80);
    host_wr(2'h3, 8'hA1);
    host_wr(2'h3, 8'hA2);
    check("ready", ready, 1'b0);
    // Strobe while full is lost by design
    host_wr(2'h3, 8'hA3);
    press(SW_RUN_HALT, 8'h80);
    check("run", run, 1'b0);
    a = 8'(8'h11 + (execs - n));
    check("addr", alamp, a);
    check("field", {f_hi, f_lo}, 2'h2);
    check("data", dlamp, 8'hA2);
    check("ready", ready, 1'b1);
    check("ram", ram.mem[{a, 2'h1}], 8'hA1);
    check("ram", ram.mem[{a, 2'h2}], 8'hA2);
    // Once halted no further microinstruction may run
    n = execs;
    repeat (10) @(posedge ref_clk);
    #1;
    check("execs", 16'(execs - n), 16'h0000);
    press(SW_RUN_HALT, 8'h00);
    check("run", run, 1'b1);
    press(SW_MRESET, 8'h00);
    check("run", run, 1'b0);
    check("addr", alamp, 8'h00);
    press(SW_RUN_HALT, 8'h00);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    check("run", run, 1'b0);
    check("addr", alamp, 8'h00);
    give_verdict();
  end
  initial begin
    repeat (8000) @(posedge ref_clk);
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
